// File: design/cmvc_pkg.sv
// constants and types shared by the call mode and vector control block
`default_nettype none
package cmvc_pkg;
  // stack bank select register
  localparam int SBS_W = 4;
  localparam int SBS_MODE_BIT = 3;
  localparam logic [3:0] SBS_RESET = 4'h8;
  localparam logic [3:0] SBS_LEGACY = 4'h8;
  localparam logic [3:0] SBS_EXTENDED = 4'h0;

  // program memory map
  localparam int PM_ADDR_W = 16;
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
  localparam logic [15:0] INT_VEC_BASE = 16'h0002;
  localparam logic [15:0] INT_VEC_LAST = 16'h000D;
  localparam logic [2:0] NUM_INT_VEC = 3'h6;
  localparam logic [15:0] TABLE_BASE = 16'h0020;
  localparam logic [15:0] TABLE_LAST = 16'h007F;
  localparam logic [5:0] TABLE_ENTRIES = 6'h30;

  // vector byte layout: first byte carries flags and high address bits
  localparam int VEC_MBE_BIT = 7;
  localparam int VEC_RBE_BIT = 6;
  localparam int START_ADDR_W = 14;

  // stacking and call timing
  localparam logic [1:0] PUSH_BYTES_LEGACY = 2'h2;
  localparam logic [1:0] PUSH_BYTES_EXTENDED = 2'h3;
  localparam logic [2:0] CALL_CYC_LEGACY = 3'h3;
  localparam logic [2:0] CALL_CYC_EXTENDED = 3'h4;
  localparam logic [2:0] FAST_CYC_LEGACY = 3'h2;
  localparam logic [2:0] FAST_CYC_EXTENDED = 3'h3;

  // noise filter time and its cycle count
  localparam int CLK_PERIOD_NS = 100;
  localparam int NOISE_FILTER_NS = 1000;
  localparam int NOISE_FILTER_CYC = (NOISE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pin positions on the synchroniser
  localparam int PIN_BOTH = 0;
  localparam int PIN_FILT = 1;
  localparam int PIN_ASYNC = 2;
  localparam int PIN_RISE = 3;
  localparam int PIN_KEY0 = 4;
  localparam int PIN_TIMER = 12;
  localparam int PIN_N = 13;

  // request flag positions
  localparam int FLAG_BOTH = 0;
  localparam int FLAG_FILT = 1;
  localparam int FLAG_ASYNC = 2;
  localparam int FLAG_RISE = 3;
  localparam int FLAG_KEY = 4;
  localparam int FLAG_N = 5;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_CALL, KIND_FAST_CALL, KIND_ABS_CALL, KIND_ABS_BRANCH, KIND_RETURN, KIND_TABLE_CALL
  } cmvc_kind_e;

  typedef enum logic [1:0] {ENTRY_TWO_BYTE, ENTRY_THREE_BYTE, ENTRY_PAIR_ONE_BYTE} cmvc_entry_e;

  typedef enum logic [1:0] {PUR_RESET, PUR_INT, PUR_TABLE} cmvc_purpose_e;
endpackage : cmvc_pkg
`default_nettype wire

// File: design/cmvc_edge_sync.sv
// two-stage synchroniser with edge detection per pin
`default_nettype none
module cmvc_edge_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised level and edges
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic next_meta;
    logic next_sync;
    logic next_prev;
    // meta feeds only sync; edges look at sync and prev
    always_comb begin
      next_meta = pin_in[i];
      next_sync = meta[i];
      next_prev = sync[i];
    end
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        meta[i] <= 1'b0;
        sync[i] <= 1'b0;
        prev[i] <= 1'b0;
      end else begin
        meta[i] <= next_meta;
        sync[i] <= next_sync;
        prev[i] <= next_prev;
      end
    end
    assign level_out[i] = sync[i];
    assign rise_out[i] = sync[i] & ~prev[i];
    assign fall_out[i] = ~sync[i] & prev[i];
  end
endmodule : cmvc_edge_sync
`default_nettype wire

// File: design/cmvc_core.sv
// call mode control, vector and table fetch, and edge input flags
`default_nettype none
module cmvc_core #(
  parameter int FILTER_CYC = cmvc_pkg::NOISE_FILTER_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // stack bank select register
  input wire logic sbs_wr_in,
  input wire logic [3:0] sbs_wdata_in,
  output logic [3:0] sbs_rdata_out,
  output logic extended_mode_out,
  // instruction requests
  input wire logic instr_valid_in,
  input wire cmvc_pkg::cmvc_kind_e instr_kind_in,
  input wire logic [15:0] ret_pc_in,
  input wire logic [5:0] table_index_in,
  input wire cmvc_pkg::cmvc_entry_e entry_kind_in,
  output logic exec_ok_out,
  output logic unavailable_out,
  output logic [1:0] push_count_out,
  output logic [1:0] pop_count_out,
  output logic [23:0] push_data_out,
  output logic [2:0] call_cycles_out,
  // interrupt acceptance
  input wire logic int_accept_in,
  input wire logic [2:0] int_vector_in,
  // program memory
  output logic pm_rd_out,
  output logic [15:0] pm_addr_out,
  input wire logic pm_ack_in,
  input wire logic [7:0] pm_data_in,
  // vector and table results
  output logic busy_out,
  output logic vector_load_out,
  output logic vector_is_reset_out,
  output logic [13:0] start_addr_out,
  output logic rbe_out,
  output logic mbe_out,
  output logic table_valid_out,
  output logic [7:0] table_byte0_out,
  output logic [7:0] table_byte1_out,
  output cmvc_pkg::cmvc_entry_e table_kind_out,
  // edge inputs and their controls
  input wire logic both_edge_interrupt_input_in,
  input wire logic filtered_edge_interrupt_input_in,
  input wire logic filter_enable_in,
  input wire logic filtered_edge_sel_in,
  input wire logic async_edge_interrupt_input_in,
  input wire logic async_edge_sel_in,
  input wire logic rising_testable_input_in,
  input wire logic [7:0] key_return_inputs_in,
  input wire logic timer_event_input_in,
  input wire logic event_count_sel_in,
  input wire logic event_edge_sel_in,
  // request flags
  input wire logic [4:0] flag_clear_in,
  output logic [4:0] flags_out,
  output logic timer_event_pulse_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} cmvc_state_e;

  logic [12:0] pins;
  logic [12:0] lvl;
  logic [12:0] rise;
  logic [12:0] fall;
  cmvc_state_e state, next_state;
  cmvc_pkg::cmvc_purpose_e purpose, next_purpose;
  cmvc_pkg::cmvc_entry_e kind_lat, next_kind_lat;
  logic phase, next_phase;
  logic [15:0] base, next_base;
  logic [7:0] byte0, next_byte0;
  logic [3:0] next_sbs;
  logic next_ext;
  logic next_exec_ok, next_unavail;
  logic [1:0] next_push, next_pop;
  logic [23:0] next_push_data;
  logic [2:0] next_cycles;
  logic next_pm_rd;
  logic [15:0] next_pm_addr;
  logic next_busy, next_vload, next_vreset, next_rbe, next_mbe, next_tvalid;
  logic [13:0] next_start;
  logic [7:0] next_tb0, next_tb1;
  cmvc_pkg::cmvc_entry_e next_tkind;
  logic filt_state, filt_prev, next_filt_state;
  logic [7:0] filt_cnt, next_filt_cnt;
  logic [4:0] flag_set, next_flags;
  logic next_timer;
  logic ext_now;

  assign pins = {timer_event_input_in, key_return_inputs_in, rising_testable_input_in,
                 async_edge_interrupt_input_in, filtered_edge_interrupt_input_in, both_edge_interrupt_input_in};
  assign ext_now = ~sbs_rdata_out[cmvc_pkg::SBS_MODE_BIT];

  cmvc_edge_sync #(.WIDTH(cmvc_pkg::PIN_N)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(pins),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  // mode register, whole nibble written at once
  always_comb begin
    next_sbs = sbs_wr_in ? sbs_wdata_in : sbs_rdata_out;
    next_ext = ~next_sbs[cmvc_pkg::SBS_MODE_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sbs_rdata_out <= cmvc_pkg::SBS_RESET;
      extended_mode_out <= 1'b0;
    end else begin
      sbs_rdata_out <= next_sbs;
      extended_mode_out <= next_ext;
    end
  end

  // instruction handling and vector/table fetch sequencer
  always_comb begin
    next_state = state;
    next_purpose = purpose;
    next_kind_lat = kind_lat;
    next_phase = phase;
    next_base = base;
    next_byte0 = byte0;
    next_exec_ok = 1'b0;
    next_unavail = 1'b0;
    next_push = push_count_out;
    next_pop = pop_count_out;
    next_push_data = push_data_out;
    next_cycles = call_cycles_out;
    next_pm_rd = 1'b0;
    next_pm_addr = pm_addr_out;
    next_vload = 1'b0;
    next_vreset = vector_is_reset_out;
    next_start = start_addr_out;
    next_rbe = rbe_out;
    next_mbe = mbe_out;
    next_tvalid = 1'b0;
    next_tb0 = table_byte0_out;
    next_tb1 = table_byte1_out;
    next_tkind = table_kind_out;
    case (state)
      ST_IDLE: begin
        if (int_accept_in && int_vector_in < cmvc_pkg::NUM_INT_VEC) begin
          next_purpose = cmvc_pkg::PUR_INT;
          next_base = cmvc_pkg::INT_VEC_BASE + {12'h000, int_vector_in, 1'b0};
          next_phase = 1'b0;
          next_state = ST_ISSUE;
        end else if (instr_valid_in) begin
          next_push = 2'h0;
          next_pop = 2'h0;
          next_cycles = 3'h0;
          // extra byte carries pc bits above the 14 held in two bytes
          next_push_data = {ext_now ? {6'h00, ret_pc_in[15:14]} : 8'h00, 2'b00, ret_pc_in[13:0]};
          case (instr_kind_in)
            cmvc_pkg::KIND_CALL: begin
              next_exec_ok = 1'b1;
              next_push = ext_now ? cmvc_pkg::PUSH_BYTES_EXTENDED : cmvc_pkg::PUSH_BYTES_LEGACY;
              next_cycles = ext_now ? cmvc_pkg::CALL_CYC_EXTENDED : cmvc_pkg::CALL_CYC_LEGACY;
            end
            cmvc_pkg::KIND_FAST_CALL: begin
              next_exec_ok = 1'b1;
              next_push = ext_now ? cmvc_pkg::PUSH_BYTES_EXTENDED : cmvc_pkg::PUSH_BYTES_LEGACY;
              next_cycles = ext_now ? cmvc_pkg::FAST_CYC_EXTENDED : cmvc_pkg::FAST_CYC_LEGACY;
            end
            cmvc_pkg::KIND_ABS_CALL: begin
              next_exec_ok = ext_now;
              next_unavail = ~ext_now;
              next_push = ext_now ? cmvc_pkg::PUSH_BYTES_EXTENDED : 2'h0;
            end
            cmvc_pkg::KIND_ABS_BRANCH: begin
              next_exec_ok = ext_now;
              next_unavail = ~ext_now;
            end
            cmvc_pkg::KIND_RETURN: begin
              next_exec_ok = 1'b1;
              next_pop = ext_now ? cmvc_pkg::PUSH_BYTES_EXTENDED : cmvc_pkg::PUSH_BYTES_LEGACY;
            end
            cmvc_pkg::KIND_TABLE_CALL: begin
              if (table_index_in < cmvc_pkg::TABLE_ENTRIES) begin
                next_purpose = cmvc_pkg::PUR_TABLE;
                next_base = cmvc_pkg::TABLE_BASE + {9'h000, table_index_in, 1'b0};
                next_phase = 1'b0;
                next_state = ST_ISSUE;
              end else begin
                next_unavail = 1'b1;
              end
            end
            default: begin
              next_push = 2'h0;
            end
          endcase
        end
      end
      ST_ISSUE: begin
        next_pm_rd = 1'b1;
        next_pm_addr = base + {15'h0000, phase};
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (pm_ack_in) begin
          if (!phase) begin
            next_byte0 = pm_data_in;
            next_kind_lat = entry_kind_in;
            next_phase = 1'b1;
            next_state = ST_ISSUE;
          end else begin
            next_state = ST_IDLE;
            if (purpose == cmvc_pkg::PUR_TABLE) begin
              next_tvalid = 1'b1;
              next_tb0 = byte0;
              next_tb1 = pm_data_in;
              next_tkind = kind_lat;
            end else begin
              next_vload = 1'b1;
              next_vreset = (purpose == cmvc_pkg::PUR_RESET);
              next_start = {byte0[5:0], pm_data_in};
              next_rbe = byte0[cmvc_pkg::VEC_RBE_BIT];
              next_mbe = byte0[cmvc_pkg::VEC_MBE_BIT];
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_ISSUE;
      purpose <= cmvc_pkg::PUR_RESET;
      base <= cmvc_pkg::RESET_VEC_ADDR;
      phase <= 1'b0;
      kind_lat <= cmvc_pkg::ENTRY_TWO_BYTE;
      byte0 <= 8'h00;
      exec_ok_out <= 1'b0;
      unavailable_out <= 1'b0;
      push_count_out <= 2'h0;
      pop_count_out <= 2'h0;
      push_data_out <= 24'h000000;
      call_cycles_out <= 3'h0;
      pm_rd_out <= 1'b0;
      pm_addr_out <= 16'h0000;
      busy_out <= 1'b1;
      vector_load_out <= 1'b0;
      vector_is_reset_out <= 1'b0;
      start_addr_out <= 14'h0000;
      rbe_out <= 1'b0;
      mbe_out <= 1'b0;
      table_valid_out <= 1'b0;
      table_byte0_out <= 8'h00;
      table_byte1_out <= 8'h00;
      table_kind_out <= cmvc_pkg::ENTRY_TWO_BYTE;
    end else begin
      state <= next_state;
      purpose <= next_purpose;
      base <= next_base;
      phase <= next_phase;
      kind_lat <= next_kind_lat;
      byte0 <= next_byte0;
      exec_ok_out <= next_exec_ok;
      unavailable_out <= next_unavail;
      push_count_out <= next_push;
      pop_count_out <= next_pop;
      push_data_out <= next_push_data;
      call_cycles_out <= next_cycles;
      pm_rd_out <= next_pm_rd;
      pm_addr_out <= next_pm_addr;
      busy_out <= next_busy;
      vector_load_out <= next_vload;
      vector_is_reset_out <= next_vreset;
      start_addr_out <= next_start;
      rbe_out <= next_rbe;
      mbe_out <= next_mbe;
      table_valid_out <= next_tvalid;
      table_byte0_out <= next_tb0;
      table_byte1_out <= next_tb1;
      table_kind_out <= next_tkind;
    end
  end

  // noise filter: level must hold FILTER_CYC cycles before it is taken
  always_comb begin
    next_filt_state = filt_state;
    next_filt_cnt = 8'h00;
    if (!filter_enable_in) begin
      next_filt_state = lvl[cmvc_pkg::PIN_FILT];
    end else if (lvl[cmvc_pkg::PIN_FILT] != filt_state) begin
      if (filt_cnt >= 8'(FILTER_CYC - 1)) begin
        next_filt_state = lvl[cmvc_pkg::PIN_FILT];
      end else begin
        next_filt_cnt = filt_cnt + 8'h01;
      end
    end
  end

  // edge events into sticky flags, set wins over clear
  always_comb begin
    flag_set[cmvc_pkg::FLAG_BOTH] = rise[cmvc_pkg::PIN_BOTH] | fall[cmvc_pkg::PIN_BOTH];
    flag_set[cmvc_pkg::FLAG_FILT] = filtered_edge_sel_in ? (~filt_state & filt_prev)
                                                          : (filt_state & ~filt_prev);
    flag_set[cmvc_pkg::FLAG_ASYNC] = async_edge_sel_in ? fall[cmvc_pkg::PIN_ASYNC]
                                                        : rise[cmvc_pkg::PIN_ASYNC];
    flag_set[cmvc_pkg::FLAG_RISE] = rise[cmvc_pkg::PIN_RISE];
    flag_set[cmvc_pkg::FLAG_KEY] = |fall[cmvc_pkg::PIN_KEY0 +: 8];
    next_flags = (flags_out & ~flag_clear_in) | flag_set;
    next_timer = event_count_sel_in & (event_edge_sel_in ? fall[cmvc_pkg::PIN_TIMER]
                                                           : rise[cmvc_pkg::PIN_TIMER]);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      filt_state <= 1'b0;
      filt_prev <= 1'b0;
      filt_cnt <= 8'h00;
      flags_out <= 5'h00;
      timer_event_pulse_out <= 1'b0;
    end else begin
      filt_state <= next_filt_state;
      filt_prev <= filt_state;
      filt_cnt <= next_filt_cnt;
      flags_out <= next_flags;
      timer_event_pulse_out <= next_timer;
    end
  end

  // checks
  property p_mode_follow;
    @(posedge clk_in) disable iff (rst_in) sbs_wr_in |=> extended_mode_out == ~$past(sbs_wdata_in[3]);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode does not follow bit 3");
  property p_push_bytes;
    @(posedge clk_in) disable iff (rst_in) (state == ST_IDLE && !int_accept_in && instr_valid_in
      && instr_kind_in == cmvc_pkg::KIND_CALL) |=> exec_ok_out && push_count_out == ($past(ext_now) ? 2'h3 : 2'h2);
  endproperty
  a_push_bytes: assert property (p_push_bytes) else $error("wrong push byte count");
  property p_abs_refused;
    @(posedge clk_in) disable iff (rst_in) (state == ST_IDLE && !int_accept_in && instr_valid_in && !ext_now
      && instr_kind_in inside {cmvc_pkg::KIND_ABS_CALL, cmvc_pkg::KIND_ABS_BRANCH}) |=> unavailable_out && !exec_ok_out;
  endproperty
  a_abs_refused: assert property (p_abs_refused) else $error("absolute instruction ran in legacy mode");
  property p_fast_cycles;
    @(posedge clk_in) disable iff (rst_in) (state == ST_IDLE && !int_accept_in && instr_valid_in
      && instr_kind_in == cmvc_pkg::KIND_FAST_CALL) |=> call_cycles_out == ($past(ext_now) ? 3'h3 : 3'h2);
  endproperty
  a_fast_cycles: assert property (p_fast_cycles) else $error("wrong fast call cycles");
  property p_reset_mode;
    @(posedge clk_in) rst_in |=> sbs_rdata_out[3] && !extended_mode_out;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset did not select legacy mode");
  property p_reset_fetch;
    @(posedge clk_in) disable iff (rst_in) $fell(rst_in) |=> pm_rd_out && pm_addr_out == 16'h0000;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("reset vector not fetched");
  property p_int_addr;
    @(posedge clk_in) disable iff (rst_in) (state == ST_IDLE && int_accept_in && int_vector_in < 3'h6)
      |=> ##1 pm_rd_out && pm_addr_out >= 16'h0002 && pm_addr_out <= 16'h000D;
  endproperty
  a_int_addr: assert property (p_int_addr) else $error("interrupt vector address out of range");
  property p_table_addr;
    @(posedge clk_in) disable iff (rst_in) (state == ST_ISSUE && purpose == cmvc_pkg::PUR_TABLE)
      |=> pm_rd_out && pm_addr_out >= 16'h0020 && pm_addr_out <= 16'h007F;
  endproperty
  a_table_addr: assert property (p_table_addr) else $error("table address out of range");
  property p_table_bytes;
    @(posedge clk_in) disable iff (rst_in) table_valid_out |-> table_byte1_out == $past(pm_data_in) && $past(pm_ack_in);
  endproperty
  a_table_bytes: assert property (p_table_bytes) else $error("table entry bytes wrong");
  property p_both_edges;
    @(posedge clk_in) disable iff (rst_in) (rise[0] || fall[0]) |=> flags_out[0];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("both-edge flag missed");
  property p_rise_flag;
    @(posedge clk_in) disable iff (rst_in) rise[3] |=> flags_out[3];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising testable flag missed");
  property p_key_flag;
    @(posedge clk_in) disable iff (rst_in) (|fall[11:4]) |=> flags_out[4];
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key flag missed");
  property p_timer_pulse;
    @(posedge clk_in) disable iff (rst_in) (event_count_sel_in && !event_edge_sel_in && rise[12]) |=> timer_event_pulse_out;
  endproperty
  a_timer_pulse: assert property (p_timer_pulse) else $error("timer event pulse missed");
endmodule : cmvc_core
`default_nettype wire

// File: sim/cmvc_core_tb.sv
// self-checking bench for the call mode and vector control block
`default_nettype none
module cmvc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, sbs_wr_in, instr_valid_in, int_accept_in, pm_ack_in;
  logic [3:0] sbs_wdata_in;
  cmvc_pkg::cmvc_kind_e instr_kind_in;
  cmvc_pkg::cmvc_entry_e entry_kind_in;
  logic [15:0] ret_pc_in;
  logic [5:0] table_index_in;
  logic [2:0] int_vector_in;
  logic [7:0] pm_data_in, key_return_inputs_in;
  logic both_in, filt_in, filt_en, filt_sel, async_in, async_sel, rise_in, timer_in, ev_sel, ev_edge;
  logic [4:0] flag_clear_in;
  logic [3:0] sbs_rdata_out;
  logic extended_mode_out, exec_ok_out, unavailable_out, pm_rd_out, busy_out, vector_load_out;
  logic vector_is_reset_out, rbe_out, mbe_out, table_valid_out, timer_event_pulse_out;
  logic [1:0] push_count_out, pop_count_out;
  logic [23:0] push_data_out;
  logic [2:0] call_cycles_out;
  logic [15:0] pm_addr_out;
  logic [13:0] start_addr_out;
  logic [7:0] table_byte0_out, table_byte1_out;
  cmvc_pkg::cmvc_entry_e table_kind_out;
  logic [4:0] flags_out;
  int bad_count, num_checks, ext, tcount;

  cmvc_core #(.FILTER_CYC(2)) cmvc_core_inst (.clk_in(clk_in), .rst_in(rst_in), .sbs_wr_in(sbs_wr_in),
    .sbs_wdata_in(sbs_wdata_in), .sbs_rdata_out(sbs_rdata_out), .extended_mode_out(extended_mode_out),
    .instr_valid_in(instr_valid_in), .instr_kind_in(instr_kind_in), .ret_pc_in(ret_pc_in),
    .table_index_in(table_index_in), .entry_kind_in(entry_kind_in), .exec_ok_out(exec_ok_out),
    .unavailable_out(unavailable_out), .push_count_out(push_count_out), .pop_count_out(pop_count_out),
    .push_data_out(push_data_out), .call_cycles_out(call_cycles_out), .int_accept_in(int_accept_in),
    .int_vector_in(int_vector_in), .pm_rd_out(pm_rd_out), .pm_addr_out(pm_addr_out), .pm_ack_in(pm_ack_in),
    .pm_data_in(pm_data_in), .busy_out(busy_out), .vector_load_out(vector_load_out),
    .vector_is_reset_out(vector_is_reset_out), .start_addr_out(start_addr_out), .rbe_out(rbe_out),
    .mbe_out(mbe_out), .table_valid_out(table_valid_out), .table_byte0_out(table_byte0_out),
    .table_byte1_out(table_byte1_out), .table_kind_out(table_kind_out),
    .both_edge_interrupt_input_in(both_in), .filtered_edge_interrupt_input_in(filt_in),
    .filter_enable_in(filt_en), .filtered_edge_sel_in(filt_sel), .async_edge_interrupt_input_in(async_in),
    .async_edge_sel_in(async_sel), .rising_testable_input_in(rise_in), .key_return_inputs_in(key_return_inputs_in),
    .timer_event_input_in(timer_in), .event_count_sel_in(ev_sel), .event_edge_sel_in(ev_edge),
    .flag_clear_in(flag_clear_in), .flags_out(flags_out), .timer_event_pulse_out(timer_event_pulse_out));

  // clock at 100 ns
  always #50 clk_in = ~clk_in;

  // program memory contents as seen by the bench
  function automatic logic [7:0] pm_byte(input logic [15:0] a);
    return {a[2:0], a[4:0]} ^ 8'h3C;
  endfunction : pm_byte

  // memory answers each read one cycle later, data line scrambles when idle
  always @(posedge clk_in) begin
    pm_ack_in <= pm_rd_out;
    pm_data_in <= pm_rd_out ? pm_byte(pm_addr_out) : ~pm_data_in;
    if (timer_event_pulse_out === 1'b1) tcount <= tcount + 1;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic wait_done();
    logic got;
    got = 1'b0;
    for (int i = 0; i < 30 && !got; i++) begin
      @(posedge clk_in);
      #1;
      got = (vector_load_out === 1'b1) || (table_valid_out === 1'b1);
    end
    chk("done", got, 1);
  endtask : wait_done

  task automatic check_vec(input logic [15:0] a, input logic is_rst);
    logic [7:0] b0, b1;
    b0 = pm_byte(a);
    b1 = pm_byte(a + 16'h0001);
    chk("start", start_addr_out, {b0[5:0], b1});
    chk("rbe", rbe_out, b0[cmvc_pkg::VEC_RBE_BIT]);
    chk("mbe", mbe_out, b0[cmvc_pkg::VEC_MBE_BIT]);
    chk("is_reset", vector_is_reset_out, is_rst);
    chk("busy", busy_out, 0);
  endtask : check_vec

  task automatic wr_sbs(input logic [3:0] v);
    @(posedge clk_in);
    sbs_wr_in <= 1'b1;
    sbs_wdata_in <= v;
    @(posedge clk_in);
    sbs_wr_in <= 1'b0;
    #1;
    ext = !v[3];
    chk("sbs", sbs_rdata_out, v);
    chk("mode", extended_mode_out, ext);
  endtask : wr_sbs

  // one instruction, checked against the mode model
  task automatic run_instr(input cmvc_pkg::cmvc_kind_e k, input logic [5:0] idx);
    logic [15:0] pc, a;
    logic refuse, isc;
    pc = 16'($urandom);
    a = cmvc_pkg::TABLE_BASE + 16'(idx) * 16'h0002;
    refuse = (((k == cmvc_pkg::KIND_ABS_CALL) || (k == cmvc_pkg::KIND_ABS_BRANCH)) && ext == 0)
             || (k == cmvc_pkg::KIND_TABLE_CALL && idx > 47);
    isc = (k == cmvc_pkg::KIND_CALL) || (k == cmvc_pkg::KIND_FAST_CALL);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_kind_in <= k;
    ret_pc_in <= pc;
    table_index_in <= idx;
    entry_kind_in <= cmvc_pkg::cmvc_entry_e'(idx % 3);
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1;
    chk("unavail", unavailable_out, refuse);
    if (k != cmvc_pkg::KIND_TABLE_CALL) chk("exec_ok", exec_ok_out, !refuse);
    if (isc) chk("push", push_count_out, ext ? 3 : 2);
    if (isc) chk("cycles", call_cycles_out, (k == cmvc_pkg::KIND_CALL ? 3 : 2) + ext);
    if (isc) chk("data", push_data_out, {6'h00, ext ? pc[15:14] : 2'h0, 2'h0, pc[13:0]});
    if (k == cmvc_pkg::KIND_RETURN) chk("pop", pop_count_out, ext ? 3 : 2);
    if (k == cmvc_pkg::KIND_ABS_CALL && ext != 0) chk("abs_push", push_count_out, 3);
    if (k == cmvc_pkg::KIND_TABLE_CALL && !refuse) begin
      wait_done();
      chk("tb0", table_byte0_out, pm_byte(a));
      chk("tb1", table_byte1_out, pm_byte(a + 16'h0001));
      chk("tkind", table_kind_out, idx % 3);
    end
  endtask : run_instr

  // wait for an edge to pass the synchroniser, compare flags, clear them
  task automatic settle(input logic [4:0] exp);
    repeat (12) @(posedge clk_in);
    #1;
    chk("flags", flags_out, exp);
    @(posedge clk_in);
    flag_clear_in <= 5'h1F;
    @(posedge clk_in);
    flag_clear_in <= 5'h00;
  endtask : settle

  initial begin
    #500000;
    bad_count++;
    finish_test();
  end

  initial begin
    {clk_in, sbs_wr_in, instr_valid_in, int_accept_in, pm_ack_in, both_in, filt_in, filt_en, filt_sel} = '0;
    {async_in, async_sel, rise_in, timer_in, ev_sel, ev_edge, bad_count, num_checks, tcount} = '0;
    {sbs_wdata_in, ret_pc_in, table_index_in, int_vector_in, pm_data_in, flag_clear_in} = '0;
    key_return_inputs_in = 8'hFF;
    instr_kind_in = cmvc_pkg::KIND_NONE;
    entry_kind_in = cmvc_pkg::ENTRY_TWO_BYTE;
    rst_in = 1'b1;
    ext = 0;
    void'($urandom(32'hC79C));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk("rst_sbs", sbs_rdata_out, 4'h8);
    chk("rst_mode", extended_mode_out, 0);
    chk("rst_busy", busy_out, 1);
    wait_done();
    check_vec(cmvc_pkg::RESET_VEC_ADDR, 1'b1);
    // every kind but KIND_NONE in both modes, software init values first
    for (int j = 0; j < 4; j++) begin
      wr_sbs(j == 0 ? 4'h8 : j == 1 ? 4'h0 : j == 2 ? 4'h7 : 4'h8);
      for (int k = 1; k < 7; k++) run_instr(cmvc_pkg::cmvc_kind_e'(k), 6'($urandom_range(47)));
    end
    run_instr(cmvc_pkg::KIND_TABLE_CALL, 6'd47);
    run_instr(cmvc_pkg::KIND_TABLE_CALL, 6'd48);
    for (int n = 0; n < 6; n++) begin
      @(posedge clk_in);
      int_accept_in <= 1'b1;
      int_vector_in <= 3'(n);
      @(posedge clk_in);
      int_accept_in <= 1'b0;
      wait_done();
      check_vec(cmvc_pkg::INT_VEC_BASE + 16'(2 * n), 1'b0);
    end
    // edge inputs
    @(posedge clk_in);
    filt_en <= 1'b1;
    ev_sel <= 1'b1;
    async_sel <= 1'b1;
    both_in <= 1'b1;
    settle(5'h01);
    both_in <= 1'b0;
    settle(5'h01);
    filt_in <= 1'b1;
    settle(5'h02);
    filt_in <= 1'b0;
    settle(5'h00);
    async_in <= 1'b1;
    settle(5'h00);
    async_in <= 1'b0;
    settle(5'h04);
    rise_in <= 1'b1;
    settle(5'h08);
    rise_in <= 1'b0;
    settle(5'h00);
    key_return_inputs_in[$urandom_range(7)] <= 1'b0;
    settle(5'h10);
    timer_in <= 1'b1;
    settle(5'h00);
    chk("timer", tcount, 1);
    // falling selections, filter bypassed
    ev_edge <= 1'b1;
    filt_sel <= 1'b1;
    filt_en <= 1'b0;
    filt_in <= 1'b1;
    timer_in <= 1'b0;
    settle(5'h00);
    filt_in <= 1'b0;
    settle(5'h02);
    chk("timer", tcount, 2);
    finish_test();
  end
endmodule : cmvc_core_tb
`default_nettype wire
